/* rtl/dac_level_cfg.svh */
// Offsets, field positions, reset values and timing of the converter level register group
`ifndef DAC_LEVEL_CFG_SVH
`define DAC_LEVEL_CFG_SVH

// Register offsets
`define OFS_GAIN_TRIM_GROUP_B 8'h0a
`define OFS_GAIN_TRIM_GROUP_A 8'h0b
`define OFS_CONVERTER_POWER_MODE 8'h0d
`define OFS_CABLE_DETECTION 8'h10
`define OFS_PIXEL_READBACK_S_HIGH 8'h12
`define OFS_PIXEL_READBACK_Y_HIGH 8'h13
`define OFS_PIXEL_READBACK_C_HIGH 8'h14
`define OFS_PIXEL_READBACK_LOW_BITS 8'h15
`define OFS_CONTROL_PIN_READBACK 8'h16
`define OFS_DEVICE_SOFT_RESET 8'h17

// Reset values
`define RST_GAIN_TRIM 8'h00
`define RST_CONVERTER_POWER_MODE 8'h00
`define RST_CABLE_DETECTION 8'h00
`define RST_DEVICE_SOFT_RESET 8'h00

// Field positions and masks
`define CABLE_UNCONN_LSB 0
`define CABLE_UNCONN_MSB 1
`define CABLE_AUTO_PD_BIT 4
`define LOW_POWER_MASK 8'h07
`define SOFT_RESET_BIT 1
`define PIX_HIGH_MSB 9
`define PIX_HIGH_LSB 2
`define PIX_LOW_MSB 1
`define PIX_LOW_LSB 0

// Legal gain code ranges: up to max raise, and from max cut upward
`define GAIN_POS_MAX 8'h40
`define GAIN_NEG_MIN 8'hc0

// Soft reset hold time in ns, and cycles at the 20 ns clock
`define SOFT_RESET_HOLD_NS 320
`define CLK_PERIOD_NS 20
`define SOFT_RESET_HOLD_CYCLES ((`SOFT_RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* rtl/dac_level_pkg.sv */
// Types shared by the converter level register group
package dac_level_pkg;

  // Register port request from the host serial port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Pixel input buses
  typedef struct packed {
    logic [9:0] s;
    logic [9:0] y;
    logic [9:0] c;
  } pixel_bus_s;

  // Sync, blank and flag pins, packed in readback bit order 5..0
  typedef struct packed {
    logic field_or_serial_out_pin;
    logic s_hsync;
    logic s_vsync;
    logic p_hsync;
    logic p_vsync;
    logic p_blank;
  } ctrl_pins_s;

  typedef enum logic [1:0] {
    SR_IDLE = 2'b00,
    SR_HOLD = 2'b01,
    SR_DONE = 2'b10
  } soft_reset_state_e;

endpackage

/* rtl/pin_sync.sv */
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Asynchronous pins in, synchronised levels out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= '0;
      q_r <= '0;
    end
    else
    begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule

/* rtl/dac_level_power_readback_regs.sv */
// Converter gain trim, power mode, cable detect, pin readback and soft reset registers
//
// Behaviour
// - Two 8-bit gain trims: group B converters 4-6, group A converters 1-3, reset zero.
// - Positive codes raise output 0.018 percent per step, up to code 0x40.
// - Codes with top two bits set lower output as two's complement.
// - Power bit 0 puts converter one in low power; register resets zero.
// - Power bits 1 and 2 low power for converters two, three; upper bits reserved.
// - Cable bit 0 reads one when converter one unconnected, zero with load.
// - Cable bit 1 same for converter two; writes to status bits ignored.
// - Cable bit 4 set powers down unconnected converters automatically; resets zero.
// - Three read-only registers return bits 9:2 of S, Y and C buses.
// - Low-bits register: C[1:0], Y[1:0], S[1:0] in bits 1:0, 3:2, 5:4.
// - Control readback: blank, vsync, hsync, secondary syncs, flag pin in bits 0-5.
// - Pixel and control readback have no defined reset value; they track pins.
// - Writing one to reset bit resets the device; the bit self-clears.
`timescale 1ns/1ns
`include "dac_level_cfg.svh"
module dac_level_power_readback_regs #(
  parameter int NUM_CONVERTERS = 6,
  parameter int NUM_LOW_POWER = 3,
  parameter int NUM_SENSED = 2,
  parameter int HOLD_CYCLES = `SOFT_RESET_HOLD_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port from the host serial port
  input wire dac_level_pkg::reg_req_s reg_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Pins sampled for readback
  input wire dac_level_pkg::pixel_bus_s pixel_pins,
  input wire dac_level_pkg::ctrl_pins_s ctrl_pins,
  // Load sense from the analog outputs, high when no cable
  input wire logic [NUM_SENSED-1:0] load_absent,
  // Converter controls
  output logic [NUM_CONVERTERS-1:0][7:0] converter_gain,
  output logic [NUM_CONVERTERS-1:0] gain_code_legal,
  output logic [NUM_LOW_POWER-1:0] converter_low_power,
  output logic [NUM_CONVERTERS-1:0] converter_power_down,
  // Device-wide reset request during the soft reset hold, low in the release cycle
  output logic device_reset
);

  localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYCLES - 1);

  // Synchronised pin levels
  dac_level_pkg::pixel_bus_s pixel_sync;
  dac_level_pkg::ctrl_pins_s ctrl_sync;
  logic [NUM_SENSED-1:0] absent_sync;

  pin_sync #(
    .WIDTH($bits(dac_level_pkg::pixel_bus_s))
  ) u_pixel_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d(pixel_pins),
    .q(pixel_sync)
  );

  pin_sync #(
    .WIDTH($bits(dac_level_pkg::ctrl_pins_s))
  ) u_ctrl_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d(ctrl_pins),
    .q(ctrl_sync)
  );

  pin_sync #(
    .WIDTH(NUM_SENSED)
  ) u_absent_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d(load_absent),
    .q(absent_sync)
  );

  // Writable registers, plus the registered read data and read valid
  logic [7:0] gain_trim_group_b_r;
  logic [7:0] gain_trim_group_b_nxt;
  logic [7:0] gain_trim_group_a_r;
  logic [7:0] gain_trim_group_a_nxt;
  logic [7:0] converter_power_mode_r;
  logic [7:0] converter_power_mode_nxt;
  logic auto_power_down_r;
  logic auto_power_down_nxt;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic rd_valid_r;

  // Soft reset sequencer
  dac_level_pkg::soft_reset_state_e sr_state_r;
  dac_level_pkg::soft_reset_state_e sr_state_nxt;
  logic [HOLD_W-1:0] hold_cnt_r;
  logic [HOLD_W-1:0] hold_cnt_nxt;

  // Address decode
  wire sel_gain_b = reg_req.addr == `OFS_GAIN_TRIM_GROUP_B;
  wire sel_gain_a = reg_req.addr == `OFS_GAIN_TRIM_GROUP_A;
  wire sel_power = reg_req.addr == `OFS_CONVERTER_POWER_MODE;
  wire sel_cable = reg_req.addr == `OFS_CABLE_DETECTION;
  wire sel_pix_s = reg_req.addr == `OFS_PIXEL_READBACK_S_HIGH;
  wire sel_pix_y = reg_req.addr == `OFS_PIXEL_READBACK_Y_HIGH;
  wire sel_pix_c = reg_req.addr == `OFS_PIXEL_READBACK_C_HIGH;
  wire sel_pix_low = reg_req.addr == `OFS_PIXEL_READBACK_LOW_BITS;
  wire sel_ctrl = reg_req.addr == `OFS_CONTROL_PIN_READBACK;
  wire sel_soft_reset = reg_req.addr == `OFS_DEVICE_SOFT_RESET;

  // Writes are refused during the soft reset hold and the release cycle after it
  wire resetting = sr_state_r != dac_level_pkg::SR_IDLE;
  wire wr_ok = reg_req.wr && !resetting;
  wire wr_gain_b = wr_ok && sel_gain_b;
  wire wr_gain_a = wr_ok && sel_gain_a;
  wire wr_power = wr_ok && sel_power;
  wire wr_cable = wr_ok && sel_cable;
  wire wr_soft_reset = wr_ok && sel_soft_reset;
  wire soft_reset_req = wr_soft_reset && reg_req.wdata[`SOFT_RESET_BIT];

  // Register next values; the soft reset forces reset values
  always_comb
  begin
    gain_trim_group_b_nxt = gain_trim_group_b_r;
    gain_trim_group_a_nxt = gain_trim_group_a_r;
    converter_power_mode_nxt = converter_power_mode_r;
    auto_power_down_nxt = auto_power_down_r;
    if (resetting)
    begin
      gain_trim_group_b_nxt = `RST_GAIN_TRIM;
      gain_trim_group_a_nxt = `RST_GAIN_TRIM;
      converter_power_mode_nxt = `RST_CONVERTER_POWER_MODE;
      auto_power_down_nxt = 1'(`RST_CABLE_DETECTION >> `CABLE_AUTO_PD_BIT);
    end
    else
    begin
      if (wr_gain_b)
      begin
        gain_trim_group_b_nxt = reg_req.wdata;
      end
      if (wr_gain_a)
      begin
        gain_trim_group_a_nxt = reg_req.wdata;
      end
      if (wr_power)
      begin
        converter_power_mode_nxt = reg_req.wdata & `LOW_POWER_MASK;
      end
      if (wr_cable)
      begin
        // Status bits are not written, only the auto power-down enable
        auto_power_down_nxt = reg_req.wdata[`CABLE_AUTO_PD_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      gain_trim_group_b_r <= `RST_GAIN_TRIM;
      gain_trim_group_a_r <= `RST_GAIN_TRIM;
      converter_power_mode_r <= `RST_CONVERTER_POWER_MODE;
      auto_power_down_r <= 1'(`RST_CABLE_DETECTION >> `CABLE_AUTO_PD_BIT);
    end
    else
    begin
      gain_trim_group_b_r <= gain_trim_group_b_nxt;
      gain_trim_group_a_r <= gain_trim_group_a_nxt;
      converter_power_mode_r <= converter_power_mode_nxt;
      auto_power_down_r <= auto_power_down_nxt;
    end
  end

  // Soft reset sequencer: hold, then one cycle of release
  always_comb
  begin
    sr_state_nxt = sr_state_r;
    hold_cnt_nxt = hold_cnt_r;
    case (sr_state_r)
      dac_level_pkg::SR_IDLE:
      begin
        if (soft_reset_req)
        begin
          sr_state_nxt = dac_level_pkg::SR_HOLD;
          hold_cnt_nxt = '0;
        end
      end
      dac_level_pkg::SR_HOLD:
      begin
        if (hold_cnt_r == HOLD_LAST)
        begin
          sr_state_nxt = dac_level_pkg::SR_DONE;
        end
        else
        begin
          hold_cnt_nxt = hold_cnt_r + HOLD_W'(1);
        end
      end
      dac_level_pkg::SR_DONE:
      begin
        sr_state_nxt = dac_level_pkg::SR_IDLE;
        hold_cnt_nxt = '0;
      end
      default:
      begin
        sr_state_nxt = dac_level_pkg::SR_IDLE;
        hold_cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sr_state_r <= dac_level_pkg::SR_IDLE;
      hold_cnt_r <= '0;
    end
    else
    begin
      sr_state_r <= sr_state_nxt;
      hold_cnt_r <= hold_cnt_nxt;
    end
  end

  assign device_reset = sr_state_r == dac_level_pkg::SR_HOLD;

  // Read-back fields
  wire [7:0] cable_view;
  wire [7:0] soft_reset_view;
  wire [7:0] pix_s_view;
  wire [7:0] pix_y_view;
  wire [7:0] pix_c_view;
  wire [7:0] pix_low_view;
  wire [7:0] ctrl_view;

  assign cable_view = {3'h0, auto_power_down_r, 2'h0, absent_sync};
  assign soft_reset_view = {6'h00, device_reset, 1'b0};
  assign pix_s_view = pixel_sync.s[`PIX_HIGH_MSB:`PIX_HIGH_LSB];
  assign pix_y_view = pixel_sync.y[`PIX_HIGH_MSB:`PIX_HIGH_LSB];
  assign pix_c_view = pixel_sync.c[`PIX_HIGH_MSB:`PIX_HIGH_LSB];
  assign pix_low_view = {2'h0,
                         pixel_sync.s[`PIX_LOW_MSB:`PIX_LOW_LSB],
                         pixel_sync.y[`PIX_LOW_MSB:`PIX_LOW_LSB],
                         pixel_sync.c[`PIX_LOW_MSB:`PIX_LOW_LSB]};
  assign ctrl_view = {2'h0, ctrl_sync};

  // Read multiplexer, unmapped offsets read zero
  always_comb
  begin
    rd_data_nxt = 8'h00;
    case (1'b1)
      sel_gain_b:
      begin
        rd_data_nxt = gain_trim_group_b_r;
      end
      sel_gain_a:
      begin
        rd_data_nxt = gain_trim_group_a_r;
      end
      sel_power:
      begin
        rd_data_nxt = converter_power_mode_r;
      end
      sel_cable:
      begin
        rd_data_nxt = cable_view;
      end
      sel_pix_s:
      begin
        rd_data_nxt = pix_s_view;
      end
      sel_pix_y:
      begin
        rd_data_nxt = pix_y_view;
      end
      sel_pix_c:
      begin
        rd_data_nxt = pix_c_view;
      end
      sel_pix_low:
      begin
        rd_data_nxt = pix_low_view;
      end
      sel_ctrl:
      begin
        rd_data_nxt = ctrl_view;
      end
      sel_soft_reset:
      begin
        rd_data_nxt = soft_reset_view;
      end
      default:
      begin
        rd_data_nxt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_valid_r <= reg_req.rd;
      if (reg_req.rd)
      begin
        rd_data_r <= rd_data_nxt;
      end
    end
  end

  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;

  // Per-converter gain: converters 1-3 from group A, 4-6 from group B
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CONVERTERS; gi++)
    begin : g_gain
      wire [7:0] code = (gi < NUM_CONVERTERS / 2) ? gain_trim_group_a_r
                                                 : gain_trim_group_b_r;
      // Raise for 0x00..0x40, two's-complement cut for 0xc0..0xff
      wire raise_ok = code <= `GAIN_POS_MAX;
      wire cut_ok = code >= `GAIN_NEG_MIN;
      assign converter_gain[gi] = code;
      // Other codes are undefined; flagged so the analog side can ignore them
      assign gain_code_legal[gi] = raise_ok || cut_ok;
    end
  endgenerate

  // Low power enables for the first converters
  genvar pi;
  generate
    for (pi = 0; pi < NUM_LOW_POWER; pi++)
    begin : g_low_power
      assign converter_low_power[pi] = converter_power_mode_r[pi];
    end
  endgenerate

  // Automatic power-down of sensed converters reported unconnected
  genvar di;
  generate
    for (di = 0; di < NUM_CONVERTERS; di++)
    begin : g_power_down
      if (di < NUM_SENSED)
      begin : g_sensed
        assign converter_power_down[di] = auto_power_down_r && absent_sync[di];
      end
      else
      begin : g_unsensed
        assign converter_power_down[di] = 1'b0;
      end
    end
  endgenerate

endmodule

/* sim/dac_level_monitor.sv */
// Assertion checker for the converter level register group
`timescale 1ns/1ns
module dac_level_monitor #(
  parameter int NUM_CONVERTERS = 6,
  parameter int NUM_LOW_POWER = 3,
  parameter int NUM_SENSED = 2,
  parameter int HOLD_CYCLES = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire dac_level_pkg::reg_req_s reg_req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  // Pins
  input wire dac_level_pkg::pixel_bus_s pixel_pins,
  input wire dac_level_pkg::ctrl_pins_s ctrl_pins,
  input wire logic [NUM_SENSED-1:0] load_absent,
  // Converter controls
  input wire logic [NUM_CONVERTERS-1:0][7:0] converter_gain,
  input wire logic [NUM_CONVERTERS-1:0] gain_code_legal,
  input wire logic [NUM_LOW_POWER-1:0] converter_low_power,
  input wire logic [NUM_CONVERTERS-1:0] converter_power_down,
  input wire logic device_reset
);
  logic [7:0] hold_cnt_r;
  logic rst_d_r;
  // Writes land only outside hold and release cycle
  wire wr_ok = reg_req.wr && !device_reset && !rst_d_r;
  wire [7:0] ad = reg_req.addr;

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      hold_cnt_r <= 8'h00;
      rst_d_r <= 1'b0;
    end
    else
    begin
      hold_cnt_r <= device_reset ? hold_cnt_r + 8'h01 : 8'h00;
      rst_d_r <= device_reset;
    end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_gain_group_share: assert property (converter_gain[1] == converter_gain[0] &&
    converter_gain[2] == converter_gain[0] && converter_gain[4] == converter_gain[3] &&
    converter_gain[5] == converter_gain[3]) else $error("gain groups differ");
  a_gain_a_write: assert property (wr_ok && ad == 8'h0b |=>
    converter_gain[0] == $past(reg_req.wdata)) else $error("group a gain not written");
  a_gain_b_write: assert property (wr_ok && ad == 8'h0a |=>
    converter_gain[3] == $past(reg_req.wdata)) else $error("group b gain not written");
  a_legal_code_flag: assert property (gain_code_legal[0] ==
    (converter_gain[0] <= 8'h40 || converter_gain[0] >= 8'hc0)) else $error("legal flag wrong");
  a_low_power_write: assert property (wr_ok && ad == 8'h0d |=>
    converter_low_power == $past(reg_req.wdata[2:0])) else $error("low power not written");
  a_cable_read_format: assert property (reg_req.rd && ad == 8'h10 |=>
    rd_valid && rd_data[7:5] == 3'b000 && rd_data[3:2] == 2'b00) else $error("cable read bad");
  a_readback_top_zero: assert property (reg_req.rd && (ad == 8'h15 || ad == 8'h16) |=>
    rd_valid ##0 rd_data[7:6] == 2'b00) else $error("readback top bits set");
  a_no_pd_upper: assert property (converter_power_down[5:2] == 4'h0 &&
    (converter_power_down[1:0] & ~$past(load_absent, 2)) == 2'b00)
    else $error("power down on connected or unsensed converter");
  a_soft_reset_start: assert property (wr_ok && ad == 8'h17 && reg_req.wdata[1] |=>
    device_reset) else $error("soft reset did not start");
  a_soft_reset_length: assert property ($fell(device_reset) |->
    hold_cnt_r == HOLD_CYCLES) else $error("soft reset length wrong");
  a_soft_reset_clears: assert property ($fell(device_reset) |->
    converter_gain == '0 && converter_low_power == '0) else $error("registers not cleared");

  c_soft_reset: cover property ($rose(device_reset));
  c_power_down: cover property (converter_power_down != '0);
  c_cable_read: cover property (reg_req.rd && ad == 8'h10 ##1 rd_valid);
endmodule

bind dac_level_power_readback_regs dac_level_monitor #(
  .NUM_CONVERTERS(NUM_CONVERTERS),
  .NUM_LOW_POWER(NUM_LOW_POWER),
  .NUM_SENSED(NUM_SENSED),
  .HOLD_CYCLES(HOLD_CYCLES)
) i_dac_level_monitor (
  .clk_sys(clk_sys),
  .nrst(nrst),
  .reg_req(reg_req),
  .rd_data(rd_data),
  .rd_valid(rd_valid),
  .pixel_pins(pixel_pins),
  .ctrl_pins(ctrl_pins),
  .load_absent(load_absent),
  .converter_gain(converter_gain),
  .gain_code_legal(gain_code_legal),
  .converter_low_power(converter_low_power),
  .converter_power_down(converter_power_down),
  .device_reset(device_reset)
);

/* sim/tb_top.sv */
// Self-checking bench for the converter level register group
`timescale 1ns/1ns
module tb_top;
  localparam int HOLD = 4;
  logic clk_sys;
  logic nrst;
  dac_level_pkg::reg_req_s reg_req;
  logic [7:0] rd_data;
  logic rd_valid;
  dac_level_pkg::pixel_bus_s pixel_pins;
  dac_level_pkg::ctrl_pins_s ctrl_pins;
  dac_level_pkg::pixel_bus_s px;
  dac_level_pkg::ctrl_pins_s cp;
  logic [1:0] load_absent;
  logic [5:0][7:0] converter_gain;
  logic [5:0] gain_code_legal;
  logic [2:0] converter_low_power;
  logic [5:0] converter_power_down;
  logic device_reset;
  int n_errors;
  int n_compared;
  int cycles;
  logic [7:0] codes [8] = '{8'h00, 8'h01, 8'h3f, 8'h40, 8'hc0, 8'hc1, 8'hfe, 8'hff};

  dac_level_power_readback_regs #(.HOLD_CYCLES(HOLD)) i_dac_level_power_readback_regs (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .reg_req(reg_req),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .pixel_pins(pixel_pins),
    .ctrl_pins(ctrl_pins),
    .load_absent(load_absent),
    .converter_gain(converter_gain),
    .gain_code_legal(gain_code_legal),
    .converter_low_power(converter_low_power),
    .converter_power_down(converter_power_down),
    .device_reset(device_reset)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
    #1;
  endtask

  // Read one register and compare against the expected value
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge clk_sys);
    reg_req.rd <= 1'b0;
    #1;
    check("rd_valid", 8'h01, {7'b0, rd_valid});
    check($sformatf("reg %h", a), e, rd_data);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  initial
  begin
    reg_req = '0;
    pixel_pins = '0;
    ctrl_pins = '0;
    load_absent = 2'b00;
    nrst = 1'b0;
    n_errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    rc(8'h0a, 8'h00);
    rc(8'h0b, 8'h00);
    rc(8'h0d, 8'h00);
    rc(8'h10, 8'h00);
    rc(8'h17, 8'h00);
    $display("test reset values done");
    foreach (codes[i])
    begin
      wr(8'h0b, codes[i]);
      wr(8'h0a, codes[7 - i]);
      check("gain a", codes[i], converter_gain[2]);
      check("gain b", codes[7 - i], converter_gain[5]);
      check("legal", {7'b0, codes[i] <= 8'h40 || codes[i] >= 8'hc0}, {7'b0, gain_code_legal[1]});
      rc(8'h0b, codes[i]);
    end
    $display("test gain trim done");
    wr(8'h0d, 8'hff);
    rc(8'h0d, 8'h07);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h0d, 8'h01 << i);
      check("low power", 8'h01 << i, {5'b0, converter_low_power});
    end
    $display("test power mode done");
    @(posedge clk_sys);
    load_absent <= 2'b10;
    wr(8'h10, 8'h13);
    wt(3);
    rc(8'h10, 8'h12);
    check("power down", 8'h02, {2'b0, converter_power_down});
    @(posedge clk_sys);
    load_absent <= 2'b01;
    wt(3);
    rc(8'h10, 8'h11);
    check("power down", 8'h01, {2'b0, converter_power_down});
    wr(8'h10, 8'h00);
    wt(3);
    rc(8'h10, 8'h01);
    check("power down", 8'h00, {2'b0, converter_power_down});
    $display("test cable detection done");
    for (int k = 0; k < 2; k++)
    begin
      px = k ? ~30'h25ac3e1 : 30'h25ac3e1;
      cp = k ? 6'h2d : 6'h12;
      @(posedge clk_sys);
      pixel_pins <= px;
      ctrl_pins <= cp;
      wt(3);
      rc(8'h12, px.s[9:2]);
      rc(8'h13, px.y[9:2]);
      rc(8'h14, px.c[9:2]);
      rc(8'h15, {2'b00, px.s[1:0], px.y[1:0], px.c[1:0]});
      rc(8'h16, {2'b00, cp});
    end
    rc(8'h11, 8'h00);
    $display("test pin readback done");
    wr(8'h0b, 8'h33);
    wr(8'h0d, 8'h05);
    wr(8'h10, 8'h10);
    wr(8'h17, 8'h00);
    check("no reset", 8'h00, {7'b0, device_reset});
    wr(8'h17, 8'h02);
    rc(8'h17, 8'h02);
    wt(HOLD + 2);
    check("reset end", 8'h00, {7'b0, device_reset});
    rc(8'h0b, 8'h00);
    rc(8'h0d, 8'h00);
    rc(8'h10, 8'h01);
    check("power down", 8'h00, {2'b0, converter_power_down});
    rc(8'h17, 8'h00);
    $display("test soft reset done");
    give_verdict();
  end
endmodule
